// ### src/dvc_map.svh
`ifndef DVC_MAP_SVH
`define DVC_MAP_SVH
// ****************************************
// Register offsets
// ****************************************
`define DVC_OFF_CTRL     8'h00
`define DVC_OFF_STATUS   8'h04
`define DVC_OFF_P12_SET  8'h08
`define DVC_OFF_P48_SET  8'h0c
`define DVC_OFF_COEF0    8'h10
`define DVC_OFF_DUTY     8'h38
// ****************************************
// Control register fields
// ****************************************
`define DVC_CTRL_TRIG    0
`define DVC_CTRL_MODE    1
`define DVC_CTRL_UNDERVOLTAGE_LOCKOUT_LINE    2
`define DVC_CTRL_PH_LO   4
`define DVC_CTRL_PH_W    3
// ****************************************
// Numeric constants
// ****************************************
`define DVC_PERIOD_BITS  10
`define DVC_CLK_NS       4
`define DVC_SRC_CLK_NS   20
`define DVC_SAT_MAX      32'sh0280_0000
`define DVC_ADC_SCALE    32'sh0100_0000
`define DVC_DUTY_SCALE   32'sh0199_999a
`define DVC_MAX_PHASES   4
`define DVC_SVC_DIV      16'h00ff
`endif

// ### src/dvc_pkg.sv
package dvc_pkg;
    typedef logic signed [31:0] dvc_q24_t;
    typedef enum logic [2:0] {
        DVC_IDLE, DVC_FILT, DVC_ERR, DVC_MAC, DVC_SAT, DVC_DONE
    } dvc_state_t;
    typedef struct packed {
        dvc_q24_t b0;
        dvc_q24_t b1;
        dvc_q24_t b2;
        dvc_q24_t a1;
        dvc_q24_t a2;
    } dvc_coef_t;
endpackage

// ### src/dvc_med3_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dvc_med3_if;
    logic [11:0] s0;
    logic [11:0] s1;
    logic [11:0] s2;
    logic [11:0] med;
    modport user (output s0, s1, s2, input med);
    modport filt (input s0, s1, s2, output med);
endinterface
`default_nettype wire

// ### src/dvc_med3.sv
`timescale 1ns/1ps
`default_nettype none
module dvc_med3 (
    dvc_med3_if.filt port_i
);
    logic [11:0] lo;
    logic [11:0] hi;
    // ****************************************
    // Three-sample median
    // ****************************************
    always_comb begin
        lo = (port_i.s0 < port_i.s1) ? port_i.s0 : port_i.s1;
        hi = (port_i.s0 < port_i.s1) ? port_i.s1 : port_i.s0;
        if (port_i.s2 < lo) begin
            port_i.med = lo;
        end else if (port_i.s2 > hi) begin
            port_i.med = hi;
        end else begin
            port_i.med = port_i.s2;
        end
    end
endmodule
`default_nettype wire

// ### src/dvc_loop.sv
// What this block does
// - Start one compensator update per PWM period, at its rising edge.
// - Each period start fetches latest samples, filters, computes new duty.
// - New duty is buffered and applied only from the next period.
// - Update always finishes well inside one loop period.
// - PWM period equals the loop period and never changes.
// - Busy indicator high from update start until update end.
// - Service loop copies undervoltage and fault levels into status bits.
// - On trigger, service loop drives undervoltage, direction, phase enables.
// - Samples arrive continuously, each channel three times per sequence.
// - Each result goes to its own slot; last three per channel kept.
// - Filter returns the median of the three newest results.
// - Only the three newest results before the update are used.
// - Filter jitter bounded by source sampling rate, chosen externally.
// - Output is five-coefficient weighted sum of histories shifted just before it.
// - Output saturates between 0 and 2.5 before scaling to compare value.
// - PWM counts 10 bits, 1024 cycles per period.
// - Trigger is set by writing 1 and self-clears on the same edge the outputs update.
`include "dvc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module dvc_loop #(
    parameter int PERIOD_BITS = `DVC_PERIOD_BITS,
    parameter int SVC_DIV     = `DVC_SVC_DIV
) (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hsel,
    input  wire logic                  hready,
    output logic [31:0]                hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire logic                  smp_valid,
    output logic                       smp_ready,
    input  wire logic                  smp_chan,
    input  wire logic [11:0]           smp_data,
    input  wire logic                  undervoltage_lockout_line_in,
    input  wire logic                  fault_flag_n,
    output logic                       current_setpoint_pwm,
    output logic                       undervoltage_lockout_line_oe_n,
    output logic                       direction_line,
    output logic [`DVC_MAX_PHASES-1:0] phase_enable_lines,
    output logic                       busy_indicator_led
);
    import dvc_pkg::*;

    // ****************************************
    // Sample buffer, two entries
    // ****************************************
    logic [12:0] buf_r [2];
    logic [12:0] buf_nxt [2];
    logic [1:0]  cnt_r;
    logic [1:0]  cnt_nxt;
    logic        pop;
    logic [12:0] head;
    assign smp_ready = (cnt_r != 2'h2);
    assign head = buf_r[0];
    assign pop  = (cnt_r != 2'h0);
    always_comb begin
        buf_nxt = buf_r;
        cnt_nxt = cnt_r;
        if (pop) begin
            buf_nxt[0] = buf_r[1];
        end
        if (smp_valid && smp_ready) begin
            buf_nxt[(pop ? cnt_r - 2'h1 : cnt_r) == 2'h0 ? 0 : 1] = {smp_chan, smp_data};
        end
        cnt_nxt = cnt_r + {1'b0, smp_valid && smp_ready} - {1'b0, pop};
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            buf_r[0] <= 13'h0000;
            buf_r[1] <= 13'h0000;
            cnt_r    <= 2'h0;
        end else begin
            buf_r <= buf_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // ****************************************
    // Three-deep history per channel
    // ****************************************
    logic [11:0] hist_r [2][3];
    logic [11:0] hist_nxt [2][3];
    always_comb begin
        hist_nxt = hist_r;
        if (pop) begin
            hist_nxt[head[12]][2] = hist_r[head[12]][1];
            hist_nxt[head[12]][1] = hist_r[head[12]][0];
            hist_nxt[head[12]][0] = head[11:0];
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            hist_r <= '{default: 12'h000};
        end else begin
            hist_r <= hist_nxt;
        end
    end

    // ****************************************
    // Register file
    // ****************************************
    logic [31:0] ctrl_r, ctrl_nxt;
    dvc_q24_t    set12_r, set12_nxt, set48_r, set48_nxt;
    dvc_q24_t    coef_r [10];
    dvc_q24_t    coef_nxt [10];
    logic        wr_pend_r, wr_pend_nxt;
    logic [7:0]  wr_addr_r, wr_addr_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic [1:0]  stat_r, stat_nxt;
    logic        trig_done;
    logic [PERIOD_BITS-1:0] duty_r;
    logic        acc;
    assign acc       = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rd_r;
    always_comb begin
        ctrl_nxt    = ctrl_r;
        set12_nxt   = set12_r;
        set48_nxt   = set48_r;
        coef_nxt    = coef_r;
        wr_pend_nxt = acc && hwrite;
        wr_addr_nxt = haddr[7:0];
        rd_nxt      = rd_r;
        if (trig_done) begin
            ctrl_nxt[`DVC_CTRL_TRIG] = 1'b0;
        end
        if (wr_pend_r) begin
            if (wr_addr_r == `DVC_OFF_CTRL) begin
                ctrl_nxt = hwdata;
                ctrl_nxt[`DVC_CTRL_TRIG] = hwdata[`DVC_CTRL_TRIG] | (ctrl_r[`DVC_CTRL_TRIG] & ~trig_done);
            end else if (wr_addr_r == `DVC_OFF_P12_SET) begin
                set12_nxt = hwdata;
            end else if (wr_addr_r == `DVC_OFF_P48_SET) begin
                set48_nxt = hwdata;
            end else if (wr_addr_r >= `DVC_OFF_COEF0 && wr_addr_r < `DVC_OFF_DUTY) begin
                coef_nxt[4'(wr_addr_r[7:2] - 6'h04)] = hwdata;
            end
        end
        if (acc && !hwrite) begin
            if (haddr[7:0] == `DVC_OFF_CTRL) begin
                rd_nxt = ctrl_r;
            end else if (haddr[7:0] == `DVC_OFF_STATUS) begin
                rd_nxt = {30'h0, stat_r};
            end else if (haddr[7:0] == `DVC_OFF_P12_SET) begin
                rd_nxt = set12_r;
            end else if (haddr[7:0] == `DVC_OFF_P48_SET) begin
                rd_nxt = set48_r;
            end else if (haddr[7:0] >= `DVC_OFF_COEF0 && haddr[7:0] < `DVC_OFF_DUTY) begin
                rd_nxt = coef_r[4'(haddr[7:2] - 6'h04)];
            end else if (haddr[7:0] == `DVC_OFF_DUTY) begin
                rd_nxt = 32'(duty_r);
            end else begin
                rd_nxt = 32'h0000_0000;
            end
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_r    <= 32'h0000_0000;
            set12_r   <= 32'h0000_0000;
            set48_r   <= 32'h0000_0000;
            coef_r    <= '{default: 32'h0000_0000};
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            rd_r      <= 32'h0000_0000;
        end else begin
            ctrl_r    <= ctrl_nxt;
            set12_r   <= set12_nxt;
            set48_r   <= set48_nxt;
            coef_r    <= coef_nxt;
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            rd_r      <= rd_nxt;
        end
    end

    // ****************************************
    // Service loop
    // ****************************************
    logic [2:0]  uv_sync_r, flt_sync_r;
    logic [15:0] svc_cnt_r, svc_cnt_nxt;
    logic        dir_r, dir_nxt, uv_oe_r, uv_oe_nxt;
    logic [`DVC_MAX_PHASES-1:0] ph_r, ph_nxt;
    logic [`DVC_CTRL_PH_W-1:0]  nph;
    assign nph = ctrl_r[`DVC_CTRL_PH_LO +: `DVC_CTRL_PH_W];
    always_comb begin
        svc_cnt_nxt = (svc_cnt_r == 16'(SVC_DIV)) ? 16'h0000 : svc_cnt_r + 16'h0001;
        stat_nxt    = stat_r;
        dir_nxt     = dir_r;
        uv_oe_nxt   = uv_oe_r;
        ph_nxt      = ph_r;
        trig_done   = 1'b0;
        if (svc_cnt_r == 16'(SVC_DIV)) begin
            if (uv_sync_r[1] == uv_sync_r[2]) begin
                stat_nxt[0] = uv_sync_r[2];
            end
            if (flt_sync_r[1] == flt_sync_r[2]) begin
                stat_nxt[1] = flt_sync_r[2];
            end
            if (ctrl_r[`DVC_CTRL_TRIG]) begin
                dir_nxt   = ctrl_r[`DVC_CTRL_MODE];
                uv_oe_nxt = ~ctrl_r[`DVC_CTRL_UNDERVOLTAGE_LOCKOUT_LINE];
                for (int i = 0; i < `DVC_MAX_PHASES; i++) begin
                    ph_nxt[i] = (32'(i) < 32'(nph));
                end
                trig_done = 1'b1;
            end
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            uv_sync_r  <= 3'h0;
            flt_sync_r <= 3'h7;
            svc_cnt_r  <= 16'h0000;
            stat_r     <= 2'h2;
            dir_r      <= 1'b0;
            uv_oe_r    <= 1'b1;
            ph_r       <= '0;
        end else begin
            uv_sync_r  <= {uv_sync_r[1:0], undervoltage_lockout_line_in};
            flt_sync_r <= {flt_sync_r[1:0], fault_flag_n};
            svc_cnt_r  <= svc_cnt_nxt;
            stat_r     <= stat_nxt;
            dir_r      <= dir_nxt;
            uv_oe_r    <= uv_oe_nxt;
            ph_r       <= ph_nxt;
        end
    end
    assign direction_line                 = dir_r;
    assign undervoltage_lockout_line_oe_n = uv_oe_r;
    assign phase_enable_lines             = ph_r;

    // ****************************************
    // PWM and compensator
    // ****************************************
    dvc_med3_if mif ();
    dvc_med3 u_med (.port_i(mif.filt));
    logic [PERIOD_BITS-1:0] pcnt_r, pcnt_nxt, duty_nxt, pend_r, pend_nxt;
    dvc_state_t st_r, st_nxt;
    dvc_q24_t   meas_r, meas_nxt, acc_r, acc_nxt;
    dvc_q24_t   eh_r [2][3];
    dvc_q24_t   eh_nxt [2][3];
    dvc_q24_t   yh_r [2][2];
    dvc_q24_t   yh_nxt [2][2];
    logic [2:0] k_r, k_nxt;
    logic       md, md_r, md_nxt;
    logic       pwm_r, pwm_nxt;
    dvc_q24_t   cf, op;
    logic signed [63:0] prod, sc;
    assign md = md_r;
    assign mif.s0 = hist_r[md][0];
    assign mif.s1 = hist_r[md][1];
    assign mif.s2 = hist_r[md][2];
    always_comb begin
        duty_nxt = (pcnt_r == '1) ? pend_r : duty_r;
        pcnt_nxt = pcnt_r + PERIOD_BITS'(1);
        pwm_nxt  = (pcnt_nxt < duty_nxt);
        pend_nxt = pend_r;
        st_nxt   = st_r;
        meas_nxt = meas_r;
        acc_nxt  = acc_r;
        eh_nxt   = eh_r;
        yh_nxt   = yh_r;
        k_nxt    = k_r;
        md_nxt   = (st_r == DVC_IDLE) ? dir_r : md_r;
        cf       = coef_r[5 * md];
        op       = eh_r[md][0];
        unique case (k_r)
            3'h0: begin cf = coef_r[5 * md];     op = eh_r[md][0]; end
            3'h1: begin cf = coef_r[5 * md + 1]; op = eh_r[md][1]; end
            3'h2: begin cf = coef_r[5 * md + 2]; op = eh_r[md][2]; end
            3'h3: begin cf = coef_r[5 * md + 3]; op = yh_r[md][0]; end
            default: begin cf = coef_r[5 * md + 4]; op = yh_r[md][1]; end
        endcase
        prod = 64'(cf) * 64'(op);
        sc   = 64'(acc_r) * 64'(`DVC_DUTY_SCALE);
        unique case (st_r)
            DVC_IDLE: begin
                if (pcnt_r == '0) begin
                    st_nxt = DVC_FILT;
                end
            end
            DVC_FILT: begin
                meas_nxt = dvc_q24_t'({mif.med, 12'h000});
                st_nxt   = DVC_ERR;
            end
            DVC_ERR: begin
                eh_nxt[md][2] = eh_r[md][1];
                eh_nxt[md][1] = eh_r[md][0];
                yh_nxt[md][1] = yh_r[md][0];
                eh_nxt[md][0] = 32'((64'(md ? set12_r : set48_r) * 64'(`DVC_ADC_SCALE)) >>> 24) - meas_r;
                acc_nxt = '0;
                k_nxt   = 3'h0;
                st_nxt  = DVC_MAC;
            end
            DVC_MAC: begin
                acc_nxt = acc_r + 32'(prod >>> 24);
                k_nxt   = k_r + 3'h1;
                if (k_r == 3'h4) begin
                    st_nxt = DVC_SAT;
                end
            end
            DVC_SAT: begin
                if (acc_r > `DVC_SAT_MAX) begin
                    acc_nxt = `DVC_SAT_MAX;
                end else if (acc_r < 0) begin
                    acc_nxt = '0;
                end
                st_nxt = DVC_DONE;
            end
            DVC_DONE: begin
                yh_nxt[md][0] = acc_r;
                pend_nxt = PERIOD_BITS'(sc >>> 48);
                st_nxt   = DVC_IDLE;
            end
        endcase
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            pcnt_r <= '0;
            pwm_r  <= 1'b0;
            duty_r <= '0;
            pend_r <= '0;
            st_r   <= DVC_IDLE;
            meas_r <= '0;
            acc_r  <= '0;
            eh_r   <= '{default: 32'h0000_0000};
            yh_r   <= '{default: 32'h0000_0000};
            k_r    <= 3'h0;
            md_r   <= 1'b0;
        end else begin
            pcnt_r <= pcnt_nxt;
            pwm_r  <= pwm_nxt;
            duty_r <= duty_nxt;
            pend_r <= pend_nxt;
            st_r   <= st_nxt;
            meas_r <= meas_nxt;
            acc_r  <= acc_nxt;
            eh_r   <= eh_nxt;
            yh_r   <= yh_nxt;
            k_r    <= k_nxt;
            md_r   <= md_nxt;
        end
    end
    assign current_setpoint_pwm = pwm_r;
    assign busy_indicator_led   = (st_r != DVC_IDLE);
endmodule
`default_nettype wire

// ### testbench/dvc_loop_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "dvc_map.svh"
module dvc_loop_props #(
    parameter int SVC_DIV = 255
) (
    input wire logic                        clock,
    input wire logic                        rst,
    input wire logic [31:0]                 haddr,
    input wire logic [1:0]                  htrans,
    input wire logic                        hwrite,
    input wire logic [31:0]                 hwdata,
    input wire logic                        hsel,
    input wire logic                        hready,
    input wire logic [31:0]                 hrdata,
    input wire logic                        hreadyout,
    input wire logic                        hresp,
    input wire logic                        current_setpoint_pwm,
    input wire logic                        undervoltage_lockout_line_oe_n,
    input wire logic                        direction_line,
    input wire logic [`DVC_MAX_PHASES-1:0]  phase_enable_lines,
    input wire logic                        busy_indicator_led
);
    localparam int CFG_MAX = 2 * (SVC_DIV + 1) + 4;
    logic [10:0] bsince_r;
    logic [9:0]  psince_r;
    logic [15:0] cfg_since_r;
    logic        bseen_r;
    logic        pseen_r;
    logic        ctl_ap_r;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // ********
    // Cycle counters
    // ********
    always_ff @(posedge clock) begin
        if (rst) begin
            bsince_r <= 11'h000;
            psince_r <= 10'h000;
            cfg_since_r <= 16'hffff;
            bseen_r <= 1'b0;
            pseen_r <= 1'b0;
            ctl_ap_r <= 1'b0;
        end else begin
            bsince_r <= $rose(busy_indicator_led) ? 11'h000 : bsince_r + 11'h001;
            psince_r <= $rose(current_setpoint_pwm) ? 10'h000 : psince_r + 10'h001;
            bseen_r <= bseen_r | $rose(busy_indicator_led);
            pseen_r <= pseen_r | $rose(current_setpoint_pwm);
            ctl_ap_r <= hsel && hready && htrans[1] && hwrite && haddr == 32'h0;
            if (ctl_ap_r && hwdata[0])
                cfg_since_r <= 16'h0000;
            else if (cfg_since_r != 16'hffff)
                cfg_since_r <= cfg_since_r + 16'h0001;
        end
    end
    // ********
    // Properties
    // ********
    sequence rd_unmapped;
        hsel && hready && htrans[1] && !hwrite && haddr >= 32'h3c && haddr < 32'h100;
    endsequence
    sequence busy_end;
        ##[1:1000] !busy_indicator_led;
    endsequence
    chk_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
        else $error("bus response not okay or wait state");
    chk_unmapped_zero: assert property (rd_unmapped |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_busy_period: assert property ($rose(busy_indicator_led) && bseen_r |-> bsince_r == 11'h3ff)
        else $error("update start not one period after the last");
    chk_busy_bound: assert property ($rose(busy_indicator_led) |-> busy_end)
        else $error("busy longer than bound");
    chk_pwm_period: assert property ($rose(current_setpoint_pwm) && pseen_r |-> psince_r == 10'h3ff)
        else $error("pwm period not 1024 clocks");
    chk_cfg_source: assert property (($changed(direction_line) || $changed(phase_enable_lines)
        || $changed(undervoltage_lockout_line_oe_n)) |-> cfg_since_r <= CFG_MAX)
        else $error("config pins changed without trigger");
    chk_phase_therm: assert property (phase_enable_lines inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
        else $error("phase enables not contiguous");
    chk_rst_values: assert property ($fell(rst) |-> undervoltage_lockout_line_oe_n && !direction_line
        && phase_enable_lines == 4'h0 && !busy_indicator_led)
        else $error("outputs wrong after reset");
endmodule
bind dvc_loop dvc_loop_props #(.SVC_DIV(SVC_DIV)) u_props (.clock(clock), .rst(rst), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hsel(hsel), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .current_setpoint_pwm(current_setpoint_pwm),
    .undervoltage_lockout_line_oe_n(undervoltage_lockout_line_oe_n), .direction_line(direction_line),
    .phase_enable_lines(phase_enable_lines), .busy_indicator_led(busy_indicator_led));
`default_nettype wire

// ### testbench/dvc_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
module dvc_stage_model (
    input wire logic         clock,
    input wire logic         rst,
    input wire logic         uv_low,
    input wire logic         fault_low,
    input wire logic [11:0]  level,
    input wire logic         uv_oe_n,
    output logic             uv_line,
    output logic             fault_line_n,
    input wire logic         smp_ready,
    output logic             smp_valid,
    output logic             smp_chan,
    output logic [11:0]      smp_data
);
    logic [2:0] slot_r;
    logic [2:0] nslot;
    logic       go;
    // ********
    // Open-collector lines with pull-up
    // ********
    assign uv_line = uv_oe_n & ~uv_low;
    assign fault_line_n = ~fault_low;
    // ********
    // Sequencer: three results per channel, held until taken
    // ********
    always @(posedge clock) begin
        if (rst) begin
            slot_r <= 3'h0;
            smp_valid <= 1'b0;
            smp_chan <= 1'b1;
            smp_data <= 12'h000;
        end else if (!smp_valid || smp_ready) begin
            nslot = smp_valid ? (slot_r == 3'h5 ? 3'h0 : slot_r + 3'h1) : slot_r;
            go = $urandom_range(3) != 0;
            slot_r <= nslot;
            smp_valid <= go;
            smp_chan <= nslot < 3'h3;
            smp_data <= go ? level : ~smp_data;
        end
    end
endmodule
`default_nettype wire

// ### testbench/dvc_loop_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dvc_map.svh"
module dvc_loop_tb;
    localparam int SVC = 7;
    localparam int SVW = 2 * (SVC + 1) + 8;
    localparam logic [31:0] SATD = 32'((64'(`DVC_SAT_MAX) * 64'(`DVC_DUTY_SCALE)) >>> 48);
    localparam logic [31:0] LVLD = 32'((64'(32'sh0180_0000) * 64'(`DVC_DUTY_SCALE)) >>> 48);
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hwrite, hreadyout, hresp, smp_valid, smp_ready, smp_chan;
    logic [11:0] smp_data, level;
    logic        uv_in, fault_n, pwm, uv_oe_n, dir, busy, uv_low, fault_low;
    logic [3:0]  ph;
    int          error_cnt, samples_checked;
    always #2 clock = ~clock;
    dvc_loop #(.SVC_DIV(SVC)) u_dut (.clock(clock), .rst(rst), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hsel(1'b1), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .smp_valid(smp_valid),
        .smp_ready(smp_ready), .smp_chan(smp_chan), .smp_data(smp_data),
        .undervoltage_lockout_line_in(uv_in), .fault_flag_n(fault_n), .current_setpoint_pwm(pwm),
        .undervoltage_lockout_line_oe_n(uv_oe_n), .direction_line(dir), .phase_enable_lines(ph),
        .busy_indicator_led(busy));
    dvc_stage_model u_stage (.clock(clock), .rst(rst), .uv_low(uv_low), .fault_low(fault_low),
        .level(level), .uv_oe_n(uv_oe_n), .uv_line(uv_in), .fault_line_n(fault_n),
        .smp_ready(smp_ready), .smp_valid(smp_valid), .smp_chan(smp_chan), .smp_data(smp_data));
    // ********
    // Tasks
    // ********
    task summarize;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task wait_rdy;
        for (int i = 0; i < 16; i++) begin
            @(posedge clock);
            if (hreadyout === 1'b1)
                return;
        end
        check("hready wait", 32'h1, 32'h0);
        summarize;
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= 1'b1;
        htrans <= 2'b10;
        wait_rdy;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy;
    endtask
    task rd(input logic [31:0] a, output logic [31:0] d);
        haddr <= a;
        hwrite <= 1'b0;
        htrans <= 2'b10;
        wait_rdy;
        htrans <= 2'b00;
        wait_rdy;
        d = hrdata;
    endtask
    task wait_busy;
        logic seen0;
        seen0 = 1'b0;
        for (int i = 0; i < 2200; i++) begin
            @(negedge clock);
            if (busy === 1'b1 && seen0)
                return;
            seen0 = busy === 1'b0;
        end
        check("busy wait", 32'h1, 32'h0);
        summarize;
    endtask
    task count_pwm(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(negedge clock);
            if (pwm === 1'b1)
                c++;
        end
    endtask
    function automatic logic [3:0] therm(input int n);
        return 4'((5'd1 << n) - 5'd1);
    endfunction
    // ********
    // Main sequence
    // ********
    initial begin
        logic [31:0] d, d_hi, v;
        int          m, u, c;
        int          phq[$] = '{0, 1, 2, 3, 4};
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        uv_low = 1'b0;
        fault_low = 1'b0;
        level = 12'h000;
        error_cnt = 0;
        samples_checked = 0;
        void'($urandom(37133));
        repeat (12) @(posedge clock);
        check("pins rst", 32'h2, {25'h0, ph, dir, uv_oe_n, busy});
        rst <= 1'b0;
        @(posedge clock);
        rd(`DVC_OFF_CTRL, d);
        check("ctrl rst", 32'h0, d);
        wr(32'h40, 32'hffffffff);
        rd(32'h40, d);
        check("unmapped", 32'h0, d);
        for (int i = 0; i < 4; i++) begin
            uv_low <= i[0];
            fault_low <= i[1];
            repeat (SVW) @(posedge clock);
            rd(`DVC_OFF_STATUS, d);
            check("status", {30'h0, ~i[1], ~i[0]}, d);
        end
        uv_low <= 1'b0;
        fault_low <= 1'b0;
        foreach (phq[k]) begin
            m = $urandom_range(1);
            u = $urandom_range(1);
            v = {25'h0, 3'(phq[k]), 1'b0, u[0], m[0], 1'b1};
            wr(`DVC_OFF_CTRL, v);
            repeat (SVW) @(posedge clock);
            check("cfg pins", {26'h0, therm(phq[k]), m[0], ~u[0]}, {26'h0, ph, dir, uv_oe_n});
            rd(`DVC_OFF_CTRL, d);
            check("trig clear", v & 32'hfffffffe, d);
            rd(`DVC_OFF_STATUS, d);
            check("uv level", {31'h0, ~u[0]}, d & 32'h1);
        end
        wr(`DVC_OFF_P12_SET, 32'h0000_0000);
        wr(`DVC_OFF_P48_SET, 32'h0300_0000);
        for (int j = 0; j < 10; j++)
            wr(`DVC_OFF_COEF0 + 4 * j, (j == 5) ? 32'h0100_0000 : 32'h0);
        wr(`DVC_OFF_CTRL, 32'h1);
        repeat (3072) @(posedge clock);
        rd(`DVC_OFF_DUTY, d);
        check("boost duty", 32'h0, d);
        wr(`DVC_OFF_CTRL, 32'h3);
        repeat (3072) @(posedge clock);
        wait_busy;
        repeat (20) @(posedge clock);
        wr(`DVC_OFF_P12_SET, 32'h0300_0000);
        wait_busy;
        repeat (20) @(posedge clock);
        count_pwm(990, c);
        check("pwm hold", 32'h0, c);
        wait_busy;
        count_pwm(1024, c);
        @(posedge clock);
        rd(`DVC_OFF_DUTY, d_hi);
        check("duty live", 32'h1, {31'h0, d_hi != 32'h0});
        check("pwm high", SATD, c);
        wr(`DVC_OFF_P12_SET, 32'h0500_0000);
        repeat (3072) @(posedge clock);
        rd(`DVC_OFF_DUTY, d);
        check("duty clamp hi", SATD, d);
        wr(`DVC_OFF_P12_SET, 32'h0200_0000);
        level <= 12'h800;
        repeat (3072) @(posedge clock);
        rd(`DVC_OFF_DUTY, d);
        check("duty filtered", LVLD, d);
        wr(`DVC_OFF_COEF0 + 20, 32'hff00_0000);
        repeat (3072) @(posedge clock);
        rd(`DVC_OFF_DUTY, d);
        check("duty clamp lo", 32'h0, d);
        summarize;
    end
endmodule
`default_nettype wire
